/* core/bsc_pkg.sv */
// ****************************************************************
// boundary-scan special cells: shared constants and carriers
// ****************************************************************
package bsc_pkg;

  // ****************************************************************
  // chain geometry
  // ****************************************************************
  localparam int ADC_W = 16; // converter control and observe lines
  localparam int CLK_W = 5; // scanned oscillator clock lines
  localparam int GEN_W = 10 + ADC_W; // general cells in the chain
  localparam int OBS_W = 2 + CLK_W; // observe-only cells in the chain
  localparam int CHAIN_W = GEN_W + OBS_W; // whole segment length

  // ****************************************************************
  // field positions inside the general segment (bit 0 leaves first)
  // ****************************************************************
  localparam int GEN_TWO_WIRE = 0; // two-wire drive enable
  localparam int GEN_EXT_CLK_EN = 1; // external clock input enable
  localparam int GEN_XTAL_EN = 2; // crystal oscillator enable
  localparam int GEN_RC_EN = 3; // external rc enable
  localparam int GEN_LF_EN = 4; // low-frequency crystal enable
  localparam int GEN_TIMER_EN = 5; // timer oscillator enable
  localparam int GEN_CMP_OFF = 6; // comparator off
  localparam int GEN_CMP_MUX = 7; // comparator mux select
  localparam int GEN_CMP_BG = 8; // comparator bandgap enable
  localparam int GEN_CMP_RES = 9; // comparator result
  localparam int GEN_ADC_LSB = 10; // first converter line

  // ****************************************************************
  // field positions inside the observe segment
  // ****************************************************************
  localparam int OBS_CLK_LSB = 0; // clock lines occupy bits 4..0
  localparam int OBS_NRM_RST = 5; // normal reset level
  localparam int OBS_HV_RST = 6; // high-voltage reset level

  // ****************************************************************
  // levels read for an unused clock option (ext, xtal, rc, lf, timer)
  // ****************************************************************
  localparam logic [CLK_W-1:0] CLK_IDLE_LEVEL = 5'h08; // only low-freq reads 1
  localparam logic [GEN_W-1:0] GEN_RESET = 26'h000_0000; // update latch reset
  localparam logic [OBS_W-1:0] OBS_RESET = 7'h00; // observe synchroniser reset

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADC_W-1:0] adc_lines; // converter control and observe lines
    logic comparator_result;
    logic comparator_bandgap_enable;
    logic comparator_mux_select;
    logic comparator_off;
    logic timer_oscillator_enable;
    logic low_freq_crystal_enable;
    logic external_rc_enable;
    logic crystal_oscillator_enable;
    logic external_clock_input_enable;
    logic two_wire_drive_enable;
  } bsc_gen_t;

  typedef struct packed {
    logic timer_oscillator_clock;
    logic low_freq_crystal_clock;
    logic external_rc_clock;
    logic crystal_oscillator_clock;
    logic external_clock_line;
  } bsc_clk_t;

endpackage : bsc_pkg

/* core/bsc_seg.sv */
`timescale 1ns/1ps
// ****************************************************************
// scan segment: capture, lsb-first shift, optional update latch
// ****************************************************************
module bsc_seg #(
  parameter int W = 4,
  parameter bit HAS_UPDATE = 1'b1
) (
  input wire logic tck,
  input wire logic tap_reset,
  input wire logic sel,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic si,
  input wire logic [W-1:0] cap_in,
  output logic so,
  output logic [W-1:0] upd_out
);

  logic [W-1:0] sr_r; // shift stage

  // ****************************************************************
  // per-cell capture and shift, one generate step per bit
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_cell
      // capture the functional value, else shift toward bit 0
      always_ff @(posedge tck) begin
        if (tap_reset) begin
          sr_r[i] <= 1'b0;
        end else if (sel && capture) begin
          sr_r[i] <= cap_in[i];
        end else if (sel && shift) begin
          sr_r[i] <= (i == W - 1) ? si : sr_r[(i + 1) % W];
        end
      end
      // update latch only where the cell may drive
      if (HAS_UPDATE) begin : g_upd
        always_ff @(posedge tck) begin
          if (tap_reset) begin
            upd_out[i] <= 1'b0;
          end else if (sel && update) begin
            upd_out[i] <= sr_r[i];
          end
        end
      end else begin : g_noupd
        assign upd_out[i] = 1'b0;
      end
    end
  endgenerate

  assign so = sr_r[0];

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_shift_lsb_first: assert property (@(posedge tck) disable iff (tap_reset)
    (sel && shift && !capture) |=> (sr_r[W-1] == $past(si)) && (so == $past(sr_r[W > 1 ? 1 : 0])))
    else $error("shift did not move toward bit 0");
  chk_capture_value: assert property (@(posedge tck) disable iff (tap_reset)
    (sel && capture) |=> sr_r == $past(cap_in))
    else $error("capture lost the functional value");
  chk_update_hold: assert property (@(posedge tck) disable iff (tap_reset)
    !(sel && update) |=> $stable(upd_out))
    else $error("update latch moved without update");

endmodule : bsc_seg

/* core/bsc_special_cells.sv */
`timescale 1ns/1ps
// What this block does
// - scan cell on two-wire drive enable
// - no cell for two-wire spike filter
// - observe cells for both reset levels
// - oscillator enable general, clock observe-only
// - internal rc oscillator not scanned
// - unused clock lines read fixed levels
// - enable cells keep oscillators reachable in sleep
// - load-cap setting not controllable from chain
// - general cells on all comparator signals
// - cell on every converter control/observe line
// - chain shifts least significant bit first
module bsc_special_cells (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic TCK,
  input wire logic TAP_RESET,
  input wire logic CHAIN_SELECT,
  input wire logic EXTEST_ACTIVE,
  input wire logic CAPTURE_DR,
  input wire logic SHIFT_DR,
  input wire logic UPDATE_DR,
  input wire logic TDI,
  output logic TDO,
  input wire bsc_pkg::bsc_gen_t CORE_GEN_IN,
  output bsc_pkg::bsc_gen_t PIN_GEN_OUT,
  input wire logic NORMAL_RESET_LEVEL,
  input wire logic HIGH_VOLTAGE_RESET_LEVEL,
  input wire bsc_pkg::bsc_clk_t CLOCK_LINES,
  input wire logic [bsc_pkg::CLK_W-1:0] CLOCK_OPTION_USED
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [bsc_pkg::GEN_W-1:0] gen_meta_r; // core values into tck, stage 1
  logic [bsc_pkg::GEN_W-1:0] gen_tck_r; // core values into tck, stage 2
  logic [bsc_pkg::OBS_W-1:0] obs_meta_r; // pin levels into tck, stage 1
  logic [bsc_pkg::OBS_W-1:0] obs_tck_r; // pin levels into tck, stage 2
  logic [bsc_pkg::CLK_W-1:0] used_meta_r; // option straps, stage 1
  logic [bsc_pkg::CLK_W-1:0] used_tck_r; // option straps, stage 2
  logic [bsc_pkg::OBS_W-1:0] obs_cap; // observe capture source
  logic [bsc_pkg::CLK_W-1:0] clk_cap; // clock lines after idle forcing
  logic [bsc_pkg::GEN_W-1:0] gen_upd; // general update latches (tck)
  logic [bsc_pkg::OBS_W-1:0] obs_unused; // observe cells never drive
  logic mid_so; // observe segment serial out into general segment
  logic [bsc_pkg::GEN_W-1:0] upd_meta_r; // latches into mclk, stage 1
  logic [bsc_pkg::GEN_W-1:0] upd_mclk_r; // latches into mclk, stage 2
  logic ext_meta_r; // extest level into mclk, stage 1
  logic ext_mclk_r; // extest level into mclk, stage 2
  logic [bsc_pkg::GEN_W-1:0] pin_gen_nxt; // next value toward the pins
  logic [bsc_pkg::GEN_W-1:0] pin_gen_r; // registered value toward the pins

  // ****************************************************************
  // link side: bring core and pin levels into the tck domain
  // ****************************************************************
  // core levels come from mclk, so they pass two tck flops
  always_ff @(posedge TCK) begin
    if (TAP_RESET) begin
      gen_meta_r <= bsc_pkg::GEN_RESET;
      gen_tck_r <= bsc_pkg::GEN_RESET;
    end else begin
      gen_meta_r <= CORE_GEN_IN;
      gen_tck_r <= gen_meta_r;
    end
  end

  // reset levels and oscillator clocks are free-running pins
  always_ff @(posedge TCK) begin
    if (TAP_RESET) begin
      obs_meta_r <= bsc_pkg::OBS_RESET;
      obs_tck_r <= bsc_pkg::OBS_RESET;
      used_meta_r <= '0;
      used_tck_r <= '0;
    end else begin
      // sampling a live oscillator drifts against tck; value is a guess
      obs_meta_r <= {HIGH_VOLTAGE_RESET_LEVEL, NORMAL_RESET_LEVEL, CLOCK_LINES};
      obs_tck_r <= obs_meta_r;
      used_meta_r <= CLOCK_OPTION_USED;
      used_tck_r <= used_meta_r;
    end
  end

  // ****************************************************************
  // capture sources for the observe segment
  // ****************************************************************
  // unused clock options read their fixed idle level
  always_comb begin
    for (int k = 0; k < bsc_pkg::CLK_W; k++) begin
      clk_cap[k] = used_tck_r[k] ? obs_tck_r[bsc_pkg::OBS_CLK_LSB + k]
                                 : bsc_pkg::CLK_IDLE_LEVEL[k];
    end
  end

  // internal rc oscillator and load-cap setting have no cell at all
  assign obs_cap = {obs_tck_r[bsc_pkg::OBS_HV_RST], obs_tck_r[bsc_pkg::OBS_NRM_RST],
                    clk_cap};

  // ****************************************************************
  // chain: tdi -> observe segment -> general segment -> tdo
  // ****************************************************************
  // observe-only cells: no update latch, no drive back
  bsc_seg #(.W(bsc_pkg::OBS_W), .HAS_UPDATE(1'b0)) u_obs_seg (
    .tck(TCK),
    .tap_reset(TAP_RESET),
    .sel(CHAIN_SELECT),
    .capture(CAPTURE_DR),
    .shift(SHIFT_DR),
    .update(UPDATE_DR),
    .si(TDI),
    .cap_in(obs_cap),
    .so(mid_so),
    .upd_out(obs_unused)
  );

  // general cells: two-wire enable, oscillator enables, comparator, converter
  // the two-wire input spike filter has no cell; the port-pin cells cover those pins
  bsc_seg #(.W(bsc_pkg::GEN_W), .HAS_UPDATE(1'b1)) u_gen_seg (
    .tck(TCK),
    .tap_reset(TAP_RESET),
    .sel(CHAIN_SELECT),
    .capture(CAPTURE_DR),
    .shift(SHIFT_DR),
    .update(UPDATE_DR),
    .si(mid_so),
    .cap_in(gen_tck_r),
    .so(TDO),
    .upd_out(gen_upd)
  );

  // ****************************************************************
  // core side: bring latched values and extest into mclk
  // ****************************************************************
  // each bit is a static level while extest holds, so per-bit sync is safe
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      upd_meta_r <= bsc_pkg::GEN_RESET;
      upd_mclk_r <= bsc_pkg::GEN_RESET;
      ext_meta_r <= 1'b0;
      ext_mclk_r <= 1'b0;
    end else begin
      upd_meta_r <= gen_upd;
      upd_mclk_r <= upd_meta_r;
      ext_meta_r <= EXTEST_ACTIVE;
      ext_mclk_r <= ext_meta_r;
    end
  end

  // ****************************************************************
  // override toward pins and analog blocks
  // ****************************************************************
  // latched value replaces the functional one only under extest
  always_comb begin
    pin_gen_nxt = ext_mclk_r ? upd_mclk_r : CORE_GEN_IN;
  end

  // enables stay scan-driven in sleep, so oscillator pins remain reachable
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      pin_gen_r <= bsc_pkg::GEN_RESET;
    end else begin
      pin_gen_r <= pin_gen_nxt;
    end
  end

  assign PIN_GEN_OUT = pin_gen_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_extest_drive: assert property (@(posedge MCLK) disable iff (!NRST)
    ext_mclk_r |=> pin_gen_r == $past(upd_mclk_r))
    else $error("extest did not drive the update latch");
  chk_func_pass: assert property (@(posedge MCLK) disable iff (!NRST)
    !ext_mclk_r |=> pin_gen_r == $past(CORE_GEN_IN))
    else $error("functional value not passed outside extest");
  chk_twi_enable: assert property (@(posedge MCLK) disable iff (!NRST)
    ext_mclk_r |=> PIN_GEN_OUT.two_wire_drive_enable
                   == $past(upd_mclk_r[bsc_pkg::GEN_TWO_WIRE]))
    else $error("two-wire drive enable not scan-controlled");
  chk_clk_idle: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR && !used_tck_r[3]) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_CLK_LSB + 3] == 1'b1)
    else $error("unused low-freq clock line not read as 1");
  chk_clk_idle_zero: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR && !used_tck_r[0]) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_CLK_LSB] == 1'b0)
    else $error("unused external clock line not read as 0");
  chk_reset_obs: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_HV_RST] == $past(obs_tck_r[bsc_pkg::OBS_HV_RST]))
    else $error("high-voltage reset level not captured");
  chk_nrm_reset_obs: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_NRM_RST] == $past(obs_tck_r[bsc_pkg::OBS_NRM_RST]))
    else $error("normal reset level not captured");
  // unused crystal, rc and timer lines must read 0 like the external clock
  chk_clk_idle_xtal: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR && !used_tck_r[1]) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_CLK_LSB + 1] == 1'b0)
    else $error("unused crystal clock line not read as 0");
  chk_clk_idle_rc: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR && !used_tck_r[2]) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_CLK_LSB + 2] == 1'b0)
    else $error("unused rc clock line not read as 0");
  chk_clk_idle_timer: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR && !used_tck_r[4]) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_CLK_LSB + 4] == 1'b0)
    else $error("unused timer clock line not read as 0");
  // a used clock option shows its synchronised pin level
  chk_clk_obs_used: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR && used_tck_r[0]) |=>
      u_obs_seg.sr_r[bsc_pkg::OBS_CLK_LSB] == $past(obs_tck_r[bsc_pkg::OBS_CLK_LSB]))
    else $error("used external clock line not captured");
  // the two-wire drive enable cell observes the core value on capture
  chk_twi_capture: assert property (@(posedge TCK) disable iff (TAP_RESET)
    (CHAIN_SELECT && CAPTURE_DR) |=>
      u_gen_seg.sr_r[bsc_pkg::GEN_TWO_WIRE] == $past(gen_tck_r[bsc_pkg::GEN_TWO_WIRE]))
    else $error("two-wire drive enable not captured");

endmodule : bsc_special_cells

/* tb/bsc_jtag_ctrl.sv */
`timescale 1ns/1ps
// ********
// test controller model: owns the test clock and the scan strobes
// ********
module bsc_jtag_ctrl (
  output logic TCK,
  output logic TAP_RESET,
  output logic CHAIN_SELECT,
  output logic EXTEST_ACTIVE,
  output logic CAPTURE_DR,
  output logic SHIFT_DR,
  output logic UPDATE_DR,
  output logic TDI,
  input wire logic TDO
);
  // rest levels: tap held in reset, test clock still
  initial begin
    {TCK, TAP_RESET, CHAIN_SELECT, EXTEST_ACTIVE, CAPTURE_DR, SHIFT_DR, UPDATE_DR, TDI} = 8'h40;
  end

  // one 80 ns period; strobes move 1 ns after the rising edge
  task automatic pulse();
    #39 TCK = 1'b0;
    #40 TCK = 1'b1;
    #1;
  endtask : pulse

  // release tap reset after two edges so the synchronisers clear
  task automatic reset_tap();
    repeat (2) pulse();
    TAP_RESET = 1'b0;
    #39 TCK = 1'b0;
  endtask : reset_tap

  // instruction level; patterns below keep one main clock and a parked comparator
  task automatic set_extest(input logic v);
    EXTEST_ACTIVE = v;
  endtask : set_extest

  // one frame: settle, capture, 33 shifts, update
  task automatic scan(input logic sel, input logic [32:0] din, output logic [32:0] dout);
    int i;
    repeat (3) pulse();
    CHAIN_SELECT = sel;
    CAPTURE_DR = 1'b1;
    pulse();
    CAPTURE_DR = 1'b0;
    SHIFT_DR = 1'b1;
    for (i = 0; i < 33; i++) begin
      TDI = din[i];
      dout[i] = TDO;
      pulse();
    end
    SHIFT_DR = 1'b0;
    TDI = ~TDI; // released line never keeps its last bit
    UPDATE_DR = 1'b1;
    pulse();
    UPDATE_DR = 1'b0;
    CHAIN_SELECT = 1'b0;
    #39 TCK = 1'b0;
  endtask : scan
endmodule : bsc_jtag_ctrl

/* tb/bsc_special_cells_test.sv */
`timescale 1ns/1ps
// ********
// self-checking bench for the special scan cells
// ********
module bsc_special_cells_test;
  logic mclk, nrst, tck, tap_reset, sel, extest, cap, shf, upd, tdi, tdo;
  logic nrm_rst, hv_rst;
  logic [4:0] clk_used;
  logic [32:0] got;
  bsc_pkg::bsc_gen_t core_in, pin_out;
  bsc_pkg::bsc_clk_t clk_lines;
  int n_errors;
  int checked;

  bsc_jtag_ctrl ctl (.TCK(tck), .TAP_RESET(tap_reset), .CHAIN_SELECT(sel),
    .EXTEST_ACTIVE(extest), .CAPTURE_DR(cap), .SHIFT_DR(shf), .UPDATE_DR(upd),
    .TDI(tdi), .TDO(tdo));

  bsc_special_cells DUT (.MCLK(mclk), .NRST(nrst), .TCK(tck), .TAP_RESET(tap_reset),
    .CHAIN_SELECT(sel), .EXTEST_ACTIVE(extest), .CAPTURE_DR(cap), .SHIFT_DR(shf),
    .UPDATE_DR(upd), .TDI(tdi), .TDO(tdo), .CORE_GEN_IN(core_in), .PIN_GEN_OUT(pin_out),
    .NORMAL_RESET_LEVEL(nrm_rst), .HIGH_VOLTAGE_RESET_LEVEL(hv_rst),
    .CLOCK_LINES(clk_lines), .CLOCK_OPTION_USED(clk_used));

  // 125 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // counts a comparison, reports a mismatch at once
  task automatic compare(input logic [32:0] act, input logic [32:0] exp);
    checked++;
    if (act !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : compare

  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // bounded wait for the pin outputs to settle on a value
  task automatic wait_pin(input bsc_pkg::bsc_gen_t exp);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge mclk);
      #1;
      if (pin_out === exp) break;
    end
    compare({7'h00, pin_out}, {7'h00, exp});
    if (pin_out !== exp) end_of_test();
  endtask : wait_pin

  // every cell observes its own signal, chain order lsb first
  task automatic t_capture(input logic [25:0] c, input logic [4:0] k, input logic n, input logic h);
    @(posedge mclk);
    core_in <= c;
    clk_lines <= k;
    clk_used <= 5'h1F;
    nrm_rst <= n;
    hv_rst <= h;
    ctl.scan(1'b1, 33'h0_0000_0000, got);
    compare(got, {h, n, k, c});
    $display("test capture done");
  endtask : t_capture

  // unused clock options read their fixed level
  task automatic t_idle_clock(input logic [4:0] used, input logic [4:0] k, input logic [4:0] e);
    @(posedge mclk);
    clk_used <= used;
    clk_lines <= k;
    ctl.scan(1'b1, 33'h0_0000_0000, got);
    compare({28'h000_0000, got[30:26]}, {28'h000_0000, e});
    $display("test idle clock done");
  endtask : t_idle_clock

  // update latch reaches the pins only under extest; unselected frames ignored
  task automatic t_extest();
    @(posedge mclk);
    core_in <= 26'h15A_3C14;
    ctl.scan(1'b1, 33'h0_0297_0C43, got);
    repeat (4) @(posedge mclk);
    #1;
    compare({7'h00, pin_out}, 33'h0_015A_3C14);
    ctl.set_extest(1'b1);
    wait_pin(26'h297_0C43);
    ctl.scan(1'b0, 33'h1_FFFF_FFFF, got);
    core_in <= 26'h0A5_0001;
    repeat (8) @(posedge mclk);
    #1;
    compare({7'h00, pin_out}, 33'h0_0297_0C43);
    ctl.set_extest(1'b0);
    wait_pin(26'h0A5_0001);
    @(posedge mclk);
    core_in <= 26'h3FF_FFFE;
    @(posedge mclk);
    #1;
    compare({7'h00, pin_out}, 33'h0_03FF_FFFE);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    compare({7'h00, pin_out}, 33'h0_0000_0000);
    @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    compare({7'h00, pin_out}, 33'h0_03FF_FFFE);
    $display("test extest done");
  endtask : t_extest

  // main sequence
  initial begin
    n_errors = 0;
    checked = 0;
    nrst = 1'b0;
    core_in = '0;
    clk_lines = '0;
    clk_used = 5'h1F;
    nrm_rst = 1'b1;
    hv_rst = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    ctl.reset_tap();
    t_capture(26'h2A5_C3A5, 5'h15, 1'b1, 1'b0);
    t_capture(26'h15A_3C5A, 5'h0A, 1'b0, 1'b1);
    t_idle_clock(5'h00, 5'h17, bsc_pkg::CLK_IDLE_LEVEL);
    t_idle_clock(5'h05, 5'h1F, 5'h0D);
    t_extest();
    end_of_test();
  end

  // hang guard
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : bsc_special_cells_test
